// ===== pkg/mode_cmd_pkg.sv
package mode_cmd_pkg;

    localparam logic [7:0] OP_SEL10   = 8'h55;
    localparam logic [7:0] OP_SENSE6  = 8'h1A;
    localparam logic [7:0] OP_SENSE10 = 8'h5A;

    localparam int PAGE_FORMAT_FLAG_BIT         = 4;
    localparam int SAVE_PAGES_FLAG_BIT          = 0;
    localparam int DESCRIPTOR_SUPPRESS_FLAG_BIT = 3;
    localparam int VT_POS                       = 6;

    typedef enum logic [1:0] {
        VT_CURRENT = 2'h0,
        VT_CHANGE  = 2'h1,
        VT_DEFAULT = 2'h2,
        VT_SAVED   = 2'h3
    } value_type_e;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_EVAL   = 5'h02,
        ST_SEND   = 5'h04,
        ST_RECV   = 5'h08,
        ST_FINISH = 5'h10
    } state_e;

    localparam logic [5:0] PG_VENDOR0 = 6'h00;
    localparam logic [5:0] PG_DEV_A   = 6'h01;
    localparam logic [5:0] PG_DEV_B   = 6'h08;
    localparam logic [5:0] PG_ALL     = 6'h3F;
    localparam logic [1:0] SLOT_NONE  = 2'h3;
    localparam logic [1:0] NSLOT      = 2'h3;

    localparam logic [3:0] SK_NONE      = 4'h0;
    localparam logic [3:0] SK_NOT_READY = 4'h2;
    localparam logic [3:0] SK_ILLEGAL   = 4'h5;
    localparam logic [7:0] ASC_NONE      = 8'h00;
    localparam logic [7:0] ASC_NOT_READY = 8'h04;
    localparam logic [7:0] ASC_LEN_ERR   = 8'h1A;
    localparam logic [7:0] ASC_INV_OP    = 8'h20;
    localparam logic [7:0] ASC_INV_CDB   = 8'h24;
    localparam logic [7:0] ASC_INV_PARM  = 8'h26;
    localparam logic [7:0] ASC_SAVE_NS   = 8'h39;

    localparam logic [7:0]  HDR6_LEN   = 8'h04;
    localparam logic [7:0]  HDR10_LEN  = 8'h08;
    localparam logic [7:0]  BD_LEN     = 8'h08;
    localparam logic [7:0]  PAGE_PARMS = 8'h02;
    localparam logic [16:0] PAGE_BYTES = 17'h00004;
    localparam logic [16:0] LIM6       = 17'h00100;
    localparam logic [16:0] LIM10      = 17'h10000;
    localparam logic [23:0] BLK_LEN    = 24'h000200;

    // Two parameter bytes per slot; slot 0 in the low bytes
    localparam logic [47:0] DEF_VALUES = 48'h0000_1040_0A05;
    localparam logic [47:0] CHG_MASK   = 48'hFF00_FF0F_00FF;

    function automatic logic [7:0] cdb_byte(logic [79:0] c, int n);
        cdb_byte = c[79-8*n -: 8];
    endfunction : cdb_byte

    // Slots follow output order: ascending codes, vendor page 00h last
    function automatic logic [1:0] slot_of(logic [5:0] code);
        slot_of = (code == PG_DEV_A)   ? 2'h0 :
                  (code == PG_DEV_B)   ? 2'h1 :
                  (code == PG_VENDOR0) ? 2'h2 : SLOT_NONE;
    endfunction : slot_of

    function automatic logic [5:0] code_of(logic [1:0] slot);
        code_of = (slot == 2'h0) ? PG_DEV_A :
                  (slot == 2'h1) ? PG_DEV_B : PG_VENDOR0;
    endfunction : code_of

endpackage : mode_cmd_pkg

// ===== rtl/byte_streamer.sv
`timescale 1ns/10ps
module byte_streamer (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic [15:0] count,
    input  wire logic [7:0]  byte_in,
    input  wire logic        ready,
    output logic [15:0]      idx,
    output logic [7:0]       data,
    output logic             valid,
    output logic             last,
    output logic             done
);
    logic [15:0] idx_reg;
    logic [15:0] cnt_reg;
    logic        act_reg;
    logic [7:0]  data_reg;
    logic        valid_reg;
    logic        last_reg;
    wire         load   = act_reg && (!valid_reg || ready);
    wire         is_end = (idx_reg == cnt_reg - 16'h0001);

    always_ff @(posedge clk) begin
        if (rst) begin
            idx_reg   <= 16'h0000;
            cnt_reg   <= 16'h0000;
            act_reg   <= 1'b0;
            data_reg  <= 8'h00;
            valid_reg <= 1'b0;
            last_reg  <= 1'b0;
        end else if (start) begin
            idx_reg   <= 16'h0000;
            cnt_reg   <= count;
            act_reg   <= (count != 16'h0000);
            valid_reg <= 1'b0;
            last_reg  <= 1'b0;
        end else if (load) begin
            data_reg  <= byte_in;
            valid_reg <= 1'b1;
            last_reg  <= is_end;
            idx_reg   <= idx_reg + 16'h0001;
            act_reg   <= !is_end;
        end else if (valid_reg && ready) begin
            valid_reg <= 1'b0;
        end
    end

    assign idx   = idx_reg;
    assign data  = data_reg;
    assign valid = valid_reg;
    assign last  = last_reg;
    assign done  = valid_reg && ready && last_reg;

endmodule : byte_streamer

// ===== rtl/mode_parameter_commands.sv
`timescale 1ns/10ps
module mode_parameter_commands
    import mode_cmd_pkg::*;
#(
    parameter bit SAVE_IMPL = 1'b1
)(
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    input  wire logic        CDB_VALID,
    input  wire logic [79:0] CDB,
    input  wire logic        DEV_READY,
    input  wire logic        FORMAT_DONE,
    input  wire logic [7:0]  PDATA,
    input  wire logic        PDATA_VALID,
    input  wire logic        DIN_READY,
    output logic             CMD_BUSY,
    output logic             PDATA_READY,
    output logic [7:0]       DIN_DATA,
    output logic             DIN_VALID,
    output logic             DIN_LAST,
    output logic             CMD_DONE,
    output logic             CHECK_COND,
    output logic [3:0]       SENSE_KEY,
    output logic [7:0]       ADD_SENSE_CODE
);
    ////////////////////////////////////////////////////////////////////
    state_e      st_reg;
    state_e      st_next;
    logic [7:0]  op_reg;
    logic        page_format_flag_reg;
    logic        save_pages_flag_reg;
    logic        descriptor_suppress_flag_reg;
    value_type_e value_type_selector_reg;
    logic [5:0]  page_reg;
    logic [15:0] alloc_reg;
    logic [15:0] plen_reg;
    logic [7:0]  eval_asc_reg;
    logic [47:0] cur_reg;
    logic        cur_valid_reg;
    logic [47:0] sav_reg;
    logic [47:0] stg_reg;
    logic [2:0]  tch_reg;
    logic [15:0] rx_pos_reg;
    logic [15:0] bdl_reg;
    logic [1:0]  pb_reg;
    logic [1:0]  pg_slot_reg;
    logic [7:0]  rx_err_reg;
    logic        done_reg;
    logic        check_reg;
    logic [3:0]  key_reg;
    logic [7:0]  asc_reg;
    logic [15:0] out_cnt_reg;
    logic [15:0] gen_idx;
    logic        stream_done;

    ////////////////////////////////////////////////////////////////////
    // Command decode
    wire [7:0] cb1 = cdb_byte(CDB, 1);
    wire [7:0] cb2 = cdb_byte(CDB, 2);
    wire [7:0] cb4 = cdb_byte(CDB, 4);
    wire [7:0] cb7 = cdb_byte(CDB, 7);
    wire [7:0] cb8 = cdb_byte(CDB, 8);
    wire       take_cmd = (st_reg == ST_IDLE) && CDB_VALID;
    wire       sense6   = (op_reg == OP_SENSE6);
    wire       is_sense = sense6 || (op_reg == OP_SENSE10);
    wire       is_sel   = (op_reg == OP_SEL10);
    wire       all_pg   = (page_reg == PG_ALL);
    wire [1:0] pg_slot  = slot_of(page_reg);
    wire       hdr_only = (value_type_selector_reg == VT_CURRENT) &&
                          (page_reg == PG_VENDOR0);

    ////////////////////////////////////////////////////////////////////
    // Response sizing
    wire [1:0]  n_pages = hdr_only ? 2'h0 : all_pg ? NSLOT : 2'h1;
    wire [7:0]  hdr_len = sense6 ? HDR6_LEN : HDR10_LEN;
    wire [7:0]  bd_len  = descriptor_suppress_flag_reg ? 8'h00 : BD_LEN;
    wire [16:0] tot_len = 17'(hdr_len) + 17'(bd_len) +
                          17'(17'(n_pages) * PAGE_BYTES);
    wire        too_long = tot_len > (sense6 ? LIM6 : LIM10);
    wire [15:0] xfer_len = (tot_len > {1'b0, alloc_reg}) ?
                           alloc_reg : tot_len[15:0];

    ////////////////////////////////////////////////////////////////////
    // Evaluation of the descriptor
    wire bad_op   = !(is_sense || is_sel);
    wire bad_sav  = (value_type_selector_reg == VT_SAVED) && !SAVE_IMPL;
    wire not_rdy  = !DEV_READY && (value_type_selector_reg != VT_DEFAULT);
    wire bad_page = !all_pg && (pg_slot == SLOT_NONE);
    wire [7:0] sense_asc = bad_sav  ? ASC_SAVE_NS :
                           not_rdy  ? ASC_NOT_READY :
                           bad_page ? ASC_INV_CDB :
                           too_long ? ASC_INV_CDB : ASC_NONE;
    wire [7:0] sel_asc   = (save_pages_flag_reg && !SAVE_IMPL) ?
                           ASC_INV_CDB : ASC_NONE;
    wire [7:0] eval_asc  = bad_op ? ASC_INV_OP :
                           is_sense ? sense_asc : sel_asc;

    ////////////////////////////////////////////////////////////////////
    // Value sets
    // current fallback
    wire [47:0] cur_eff = cur_valid_reg ? cur_reg :
                          SAVE_IMPL ? sav_reg : DEF_VALUES;
    wire [47:0] vt_vec  =
        (value_type_selector_reg == VT_CURRENT) ? cur_eff :
        (value_type_selector_reg == VT_CHANGE)  ? CHG_MASK :
        (value_type_selector_reg == VT_DEFAULT) ? DEF_VALUES : sav_reg;

    ////////////////////////////////////////////////////////////////////
    // Response byte generator
    wire [15:0] pre_len  = 16'(hdr_len) + 16'(bd_len);
    wire [15:0] pg_off   = gen_idx - pre_len;
    wire [3:0]  bd_idx   = gen_idx[3:0] - hdr_len[3:0];
    wire [15:0] tot_m    = tot_len[15:0] - (sense6 ? 16'h0001 : 16'h0002);
    wire [1:0]  out_slot = all_pg ? pg_off[3:2] : pg_slot;
    wire [2:0]  val_addr = {out_slot, pg_off[0]};
    wire [7:0]  val_byte = vt_vec[{val_addr, 3'b000} +: 8];
    wire [2:0]  hi       = gen_idx[2:0];
    wire [7:0]  hdr6     = (hi == 3'h0) ? tot_m[7:0] :
                           (hi == 3'h3) ? bd_len : 8'h00;
    wire [7:0]  hdr10    = (hi == 3'h0) ? tot_m[15:8] :
                           (hi == 3'h1) ? tot_m[7:0] :
                           (hi == 3'h7) ? bd_len : 8'h00;
    wire [7:0]  bd_byte  = (bd_idx == 4'h5) ? BLK_LEN[23:16] :
                           (bd_idx == 4'h6) ? BLK_LEN[15:8] :
                           (bd_idx == 4'h7) ? BLK_LEN[7:0] : 8'h00;
    wire [7:0]  pg_byte  = (pg_off[1:0] == 2'h0) ?
                           {SAVE_IMPL, 1'b0, code_of(out_slot)} :
                           (pg_off[1:0] == 2'h1) ? PAGE_PARMS : val_byte;
    wire [7:0]  gen_byte = (gen_idx < 16'(hdr_len)) ?
                           (sense6 ? hdr6 : hdr10) :
                           (gen_idx < pre_len) ? bd_byte : pg_byte;
    wire        gen_start = (st_reg == ST_EVAL) && is_sense &&
                            (eval_asc == ASC_NONE) && (xfer_len != 16'h0);

    byte_streamer u_stream (
        .clk     (REF_CLK),
        .rst     (RST),
        .start   (gen_start),
        .count   (xfer_len),
        .byte_in (gen_byte),
        .ready   (DIN_READY),
        .idx     (gen_idx),
        .data    (DIN_DATA),
        .valid   (DIN_VALID),
        .last    (DIN_LAST),
        .done    (stream_done)
    );

    ////////////////////////////////////////////////////////////////////
    // Parameter list parsing
    wire        rx_take  = (st_reg == ST_RECV) && PDATA_VALID;
    wire        rx_hdr   = rx_pos_reg < 16'(HDR10_LEN);
    wire        rx_bd    = {1'b0, rx_pos_reg} <
                           17'(HDR10_LEN) + {1'b0, bdl_reg};
    wire [15:0] bdl_full = {bdl_reg[15:8], PDATA};
    wire [1:0]  rx_slot  = slot_of(PDATA[5:0]);
    wire        slot_ok  = (pg_slot_reg != SLOT_NONE);
    wire [5:0]  rx_bit   = {pg_slot_reg, pb_reg[0], 3'b000};
    wire [7:0]  cur_byte = cur_eff[rx_bit +: 8];
    wire [7:0]  chg_byte = CHG_MASK[rx_bit +: 8];
    wire [7:0]  hdr_err  = (rx_pos_reg == 16'h0007 &&
                            bdl_full != 16'h0000 &&
                            bdl_full != 16'(BD_LEN)) ? ASC_INV_PARM : ASC_NONE;
    wire [7:0]  code_err = !page_format_flag_reg ? ASC_INV_CDB :
                           (rx_slot == SLOT_NONE || PDATA[6]) ?
                           ASC_INV_PARM : ASC_NONE;
    wire        fix_hit  = slot_ok && (((PDATA ^ cur_byte) & ~chg_byte)
                           != 8'h00);
    wire [7:0]  pg_err   = (pb_reg == 2'h0) ? code_err :
                           (pb_reg == 2'h1) ?
                           ((PDATA != PAGE_PARMS) ? ASC_INV_PARM : ASC_NONE) :
                           (fix_hit ? ASC_INV_PARM : ASC_NONE);
    wire [7:0]  rx_new   = rx_hdr ? hdr_err : rx_bd ? ASC_NONE : pg_err;
    wire        rx_last  = rx_take && (rx_pos_reg + 16'h0001 == plen_reg);
    wire        rx_trunc = rx_bd || (pb_reg != 2'h0);

    ////////////////////////////////////////////////////////////////////
    // Completion
    // zero length
    wire [7:0]  rx_asc  = (!is_sel || plen_reg == 16'h0) ? ASC_NONE :
                          (rx_err_reg != ASC_NONE) ? rx_err_reg :
                          rx_trunc ? ASC_LEN_ERR : ASC_NONE;
    wire [7:0]  fin_asc = (eval_asc_reg != ASC_NONE) ? eval_asc_reg : rx_asc;
    wire [3:0]  fin_key = (fin_asc == ASC_NONE) ? SK_NONE :
                          (fin_asc == ASC_NOT_READY) ? SK_NOT_READY :
                          SK_ILLEGAL;
    wire        commit  = (st_reg == ST_FINISH) && is_sel &&
                          (fin_asc == ASC_NONE);
    wire [47:0] tch_m   = {{16{tch_reg[2]}}, {16{tch_reg[1]}},
                           {16{tch_reg[0]}}};
    wire [47:0] cur_new = (stg_reg & tch_m) | (cur_eff & ~tch_m);

    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            ST_IDLE: begin
                if (CDB_VALID) st_next = ST_EVAL;
            end
            ST_EVAL: begin
                if (eval_asc != ASC_NONE) st_next = ST_FINISH;
                else if (is_sense)
                    st_next = (xfer_len == 16'h0) ? ST_FINISH : ST_SEND;
                else st_next = (plen_reg == 16'h0) ? ST_FINISH : ST_RECV;
            end
            ST_SEND: begin
                if (stream_done) st_next = ST_FINISH;
            end
            ST_RECV: begin
                if (rx_last) st_next = ST_FINISH;
            end
            ST_FINISH: begin
                st_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) st_reg <= ST_IDLE;
        else st_reg <= st_next;
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            op_reg    <= 8'h00;
            page_format_flag_reg         <= 1'b0;
            save_pages_flag_reg          <= 1'b0;
            descriptor_suppress_flag_reg <= 1'b0;
            value_type_selector_reg      <= VT_CURRENT;
            page_reg  <= 6'h00;
            alloc_reg <= 16'h0000;
            plen_reg  <= 16'h0000;
        end else if (take_cmd) begin
            op_reg    <= cdb_byte(CDB, 0);
            page_format_flag_reg <= cb1[PAGE_FORMAT_FLAG_BIT];
            save_pages_flag_reg <= cb1[SAVE_PAGES_FLAG_BIT];
            descriptor_suppress_flag_reg <= cb1[DESCRIPTOR_SUPPRESS_FLAG_BIT];
            value_type_selector_reg <= value_type_e'(cb2[VT_POS +: 2]);
            page_reg  <= cb2[5:0];
            alloc_reg <= (cdb_byte(CDB, 0) == OP_SENSE6) ?
                         {8'h00, cb4} : {cb7, cb8};
            plen_reg  <= {cb7, cb8};
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST || st_reg == ST_EVAL) begin
            rx_pos_reg  <= 16'h0000;
            bdl_reg     <= 16'h0000;
            pb_reg      <= 2'h0;
            pg_slot_reg <= SLOT_NONE;
            rx_err_reg  <= ASC_NONE;
            tch_reg     <= 3'h0;
            stg_reg     <= 48'h0;
        end else if (rx_take) begin
            rx_pos_reg <= rx_pos_reg + 16'h0001;
            if (rx_err_reg == ASC_NONE) rx_err_reg <= rx_new;
            if (rx_pos_reg == 16'h0006) bdl_reg[15:8] <= PDATA;
            if (rx_pos_reg == 16'h0007) bdl_reg[7:0] <= PDATA;
            if (!rx_hdr && !rx_bd) begin
                pb_reg <= pb_reg + 2'h1;
                if (pb_reg == 2'h0) pg_slot_reg <= rx_slot;
                if (pb_reg[1] && slot_ok) begin
                    stg_reg[rx_bit +: 8] <= PDATA;
                    tch_reg[pg_slot_reg] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            cur_reg       <= DEF_VALUES;
            cur_valid_reg <= 1'b0;
            sav_reg       <= DEF_VALUES;
        end else if (commit) begin
            cur_reg       <= cur_new;
            cur_valid_reg <= 1'b1;
            if (save_pages_flag_reg) sav_reg <= cur_new;
        end else if (FORMAT_DONE && SAVE_IMPL) begin
            sav_reg <= cur_eff;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            eval_asc_reg <= ASC_NONE;
            done_reg     <= 1'b0;
            check_reg    <= 1'b0;
            key_reg      <= SK_NONE;
            asc_reg      <= ASC_NONE;
            out_cnt_reg  <= 16'h0000;
        end else begin
            if (st_reg == ST_EVAL) eval_asc_reg <= eval_asc;
            done_reg <= (st_reg == ST_FINISH);
            if (st_reg == ST_FINISH) begin
                check_reg <= (fin_asc != ASC_NONE);
                key_reg   <= fin_key;
                asc_reg   <= fin_asc;
            end
            if (st_reg == ST_EVAL) out_cnt_reg <= 16'h0000;
            else if (DIN_VALID && DIN_READY)
                out_cnt_reg <= out_cnt_reg + 16'h0001;
        end
    end

    assign CMD_BUSY       = (st_reg != ST_IDLE);
    assign PDATA_READY    = (st_reg == ST_RECV);
    assign CMD_DONE       = done_reg;
    assign CHECK_COND     = check_reg;
    assign SENSE_KEY      = key_reg;
    assign ADD_SENSE_CODE = asc_reg;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    AST_BAD_PAGE: assert property (
        (st_reg == ST_EVAL && is_sense && !bad_sav && !not_rdy && bad_page)
        |-> ##2 (CMD_DONE && CHECK_COND && SENSE_KEY == SK_ILLEGAL &&
                 ADD_SENSE_CODE == ASC_INV_CDB))
        else $error("unimplemented page not rejected");

    AST_SAVE_NS: assert property (
        (st_reg == ST_EVAL && is_sense &&
         value_type_selector_reg == VT_SAVED && !SAVE_IMPL)
        |-> ##2 (CMD_DONE && ADD_SENSE_CODE == ASC_SAVE_NS))
        else $error("saved values request not refused");

    AST_SUPPRESS_ZERO: assert property (
        (DIN_VALID && DIN_READY && sense6 && descriptor_suppress_flag_reg &&
         out_cnt_reg == 16'h0003) |-> (DIN_DATA == 8'h00))
        else $error("descriptor length nonzero with suppress flag");

    AST_ZERO_LEN: assert property (
        (st_reg == ST_EVAL && is_sel && eval_asc == ASC_NONE &&
         plen_reg == 16'h0) |-> ##2 (CMD_DONE && !CHECK_COND))
        else $error("zero length select reported an error");

    AST_TRUNC: assert property (
        (st_reg == ST_FINISH && eval_asc_reg == ASC_NONE && is_sel &&
         plen_reg != 16'h0 && rx_err_reg == ASC_NONE && rx_trunc)
        |=> (CMD_DONE && CHECK_COND && ADD_SENSE_CODE == ASC_LEN_ERR))
        else $error("truncated list not reported");

    AST_FIXED: assert property (
        $past(commit) |-> (((cur_reg ^ $past(cur_eff)) & ~CHG_MASK) == 48'h0))
        else $error("fixed field changed by select");

    AST_XFER_LEN: assert property (
        (CMD_DONE && is_sense && !CHECK_COND) |-> (out_cnt_reg == xfer_len))
        else $error("sense byte count wrong");

    AST_DEFAULT_RDY: assert property (
        (st_reg == ST_EVAL && is_sense &&
         value_type_selector_reg == VT_DEFAULT &&
         !bad_page && !too_long && xfer_len != 16'h0)
        |=> (st_reg == ST_SEND))
        else $error("default values not answered");

    AST_SAVE_PAGES: assert property (
        $past(commit) |-> (save_pages_flag_reg ? (sav_reg == cur_reg) :
                           $stable(sav_reg)))
        else $error("save flag handling wrong");

    COV_ALL_PAGES: cover property (CMD_DONE && is_sense && all_pg &&
                                   !CHECK_COND);
    COV_SELECT_SAVE: cover property (commit && save_pages_flag_reg &&
                                     tch_reg != 3'h0);
    COV_LEN_ERR: cover property (CMD_DONE && ADD_SENSE_CODE == ASC_LEN_ERR);

endmodule : mode_parameter_commands

// ===== verification/mode_initiator_model.sv
`timescale 1ns/10ps
module mode_initiator_model (
    input  wire logic       clk,
    input  wire logic       slow,
    input  wire logic [7:0] din_data,
    input  wire logic       din_valid,
    input  wire logic       din_last,
    input  wire logic       pdata_ready,
    output logic            din_ready,
    output logic [7:0]      pdata,
    output logic            pdata_valid
);
    logic [7:0] rx_q[$];
    logic [7:0] tx_q[$];
    int         last_at = 0;
    initial begin
        din_ready = 1'b0;
        pdata = 8'h00;
        pdata_valid = 1'b0;
    end
    // Idle data toggles so a stale byte never looks held
    always @(posedge clk) begin
        if (din_valid && din_ready) begin
            rx_q.push_back(din_data);
            if (din_last) last_at = rx_q.size();
        end
        if (pdata_valid && pdata_ready)
            void'(tx_q.pop_front());
        #1;
        din_ready = !slow || !din_ready;
        pdata_valid = tx_q.size() != 0;
        pdata = pdata_valid ? tx_q[0] : ~pdata;
    end
endmodule : mode_initiator_model

// ===== verification/mode_parameter_commands_test.sv
`timescale 1ns/10ps
module mode_parameter_commands_test;
    import mode_cmd_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cv = 1'b0;
    logic [79:0] cdb = '0;
    logic        rdy = 1'b1;
    logic        fmt = 1'b0;
    logic        slow = 1'b0;
    logic [7:0]  pdata, dout, asc, asc2, e[$];
    logic        pvalid, pready, dready, dvalid, done, cc;
    logic        dlast, busy, cc2;
    logic [3:0]  key, key2;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          tn = 0;

    mode_parameter_commands u_mode_parameter_commands (
        .REF_CLK(clk), .RST(rst), .CDB_VALID(cv), .CDB(cdb),
        .DEV_READY(rdy), .FORMAT_DONE(fmt), .PDATA(pdata),
        .PDATA_VALID(pvalid), .DIN_READY(dready), .CMD_BUSY(busy),
        .PDATA_READY(pready), .DIN_DATA(dout), .DIN_VALID(dvalid),
        .DIN_LAST(dlast), .CMD_DONE(done), .CHECK_COND(cc), .SENSE_KEY(key),
        .ADD_SENSE_CODE(asc));
    // Same commands to a unit without saved values
    mode_parameter_commands #(
        .SAVE_IMPL(1'b0)
    ) u_mode_parameter_commands_nosave (
        .REF_CLK(clk), .RST(rst), .CDB_VALID(cv), .CDB(cdb),
        .DEV_READY(rdy), .FORMAT_DONE(fmt), .PDATA(pdata),
        .PDATA_VALID(pvalid), .DIN_READY(dready), .CMD_BUSY(),
        .PDATA_READY(), .DIN_DATA(), .DIN_VALID(), .DIN_LAST(),
        .CMD_DONE(), .CHECK_COND(cc2), .SENSE_KEY(key2),
        .ADD_SENSE_CODE(asc2));
    mode_initiator_model u_mode_initiator_model (
        .clk(clk), .slow(slow), .din_data(dout), .din_valid(dvalid),
        .din_last(dlast),
        .pdata_ready(pready), .din_ready(dready), .pdata(pdata),
        .pdata_valid(pvalid));

    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            summarize();
        end
    end

    function automatic logic [79:0] s6(logic nb, logic [1:0] v,
                                       logic [5:0] p, logic [7:0] a);
        return {OP_SENSE6, 4'h0, nb, 3'h0, v, p, 8'h00, a, 40'h0};
    endfunction : s6

    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    task automatic check(input logic [15:0] s, input logic [15:0] x);
        samples_checked++;
        if (s !== x) begin
            mismatches++;
            $display("BAD t=%0t got %h want %h", $time, s, x);
        end
    endtask : check

    task automatic run(input logic [79:0] c, input logic [11:0] st);
        int n = 0;
        u_mode_initiator_model.rx_q.delete();
        u_mode_initiator_model.last_at = 0;
        cdb = c;
        cv = 1'b1;
        @(posedge clk) #1;
        cv = 1'b0;
        check(16'(busy), 16'h0001);
        while (done !== 1'b1 && n < 500) begin
            @(posedge clk) #1;
            n++;
        end
        check(16'({busy, done, cc, key, asc}), 16'({2'b01, |st[11:8], st}));
        check(16'(u_mode_initiator_model.rx_q.size()), 16'(e.size()));
        check(16'(u_mode_initiator_model.last_at), 16'(e.size()));
        foreach (e[i]) check(16'(u_mode_initiator_model.rx_q[i]), 16'(e[i]));
        tn++;
        $display("test %0d ended", tn);
    endtask : run

    task automatic hd(input logic [7:0] b0, input logic [7:0] b3);
        e = '{b0, 8'h00, 8'h00, b3};
    endtask : hd

    task automatic addpg(input int k, input logic [47:0] v);
        logic [5:0] c[3] = '{PG_DEV_A, PG_DEV_B, PG_VENDOR0};
        e.push_back({2'h2, c[k]});
        e.push_back(8'h02);
        e.push_back(v[16*k +: 8]);
        e.push_back(v[16*k+8 +: 8]);
    endtask : addpg

    task automatic sel(input logic save, input logic [7:0] p0, p1,
                       input logic [15:0] len, input logic [11:0] st);
        logic [95:0] b = {64'h0, 8'h01, 8'h02, p0, p1};
        for (int i = 0; i < len; i++)
            u_mode_initiator_model.tx_q.push_back(b[95-8*i -: 8]);
        e = {};
        run({OP_SEL10, 4'h1, 3'h0, save, 40'h0, len, 8'h00}, st);
        u_mode_initiator_model.tx_q.delete();
    endtask : sel

    initial begin
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        // mask of all pages before any select
        hd(8'h0F, 8'h00);
        for (int k = 0; k < 3; k++) addpg(k, CHG_MASK);
        run(s6(1'b1, VT_CHANGE, PG_ALL, 8'hFF), 12'h000);
        hd(8'h07, 8'h00);
        addpg(0, DEF_VALUES);
        run(s6(1'b1, VT_CURRENT, PG_DEV_A, 8'hFF), 12'h000);
        slow = 1'b1;
        sel(1'b1, 8'h33, 8'h0A, 16'h000C, 12'h000);
        hd(8'h07, 8'h00);
        addpg(0, 48'h0A33);
        run(s6(1'b1, VT_SAVED, PG_DEV_A, 8'hFF), 12'h000);
        check(16'({cc2, key2, asc2}), 16'h1539);
        sel(1'b0, 8'h44, 8'h0A, 16'h000C, 12'h000);
        hd(8'h07, 8'h00);
        addpg(0, 48'h0A33);
        run(s6(1'b1, VT_SAVED, PG_DEV_A, 8'hFF), 12'h000);
        fmt = 1'b1;
        @(posedge clk) #1;
        fmt = 1'b0;
        hd(8'h07, 8'h00);
        addpg(0, 48'h0A44);
        run(s6(1'b1, VT_SAVED, PG_DEV_A, 8'hFF), 12'h000);
        sel(1'b0, 8'h44, 8'h0B, 16'h000C, 12'h526);
        hd(8'h07, 8'h00);
        addpg(0, 48'h0A44);
        run(s6(1'b1, VT_CURRENT, PG_DEV_A, 8'hFF), 12'h000);
        sel(1'b0, 8'h44, 8'h0A, 16'h000A, 12'h51A);
        sel(1'b0, 8'h44, 8'h0A, 16'h0000, 12'h000);
        e = {};
        run(s6(1'b1, VT_CURRENT, 6'h02, 8'hFF), 12'h524);
        run(s6(1'b1, VT_CURRENT, 6'h20, 8'hFF), 12'h524);
        run({8'h15, 72'h0}, 12'h520);
        rdy = 1'b0;
        run(s6(1'b1, VT_CURRENT, PG_DEV_A, 8'hFF), 12'h204);
        hd(8'h07, 8'h00);
        addpg(1, DEF_VALUES);
        run(s6(1'b1, VT_DEFAULT, PG_DEV_B, 8'hFF), 12'h000);
        rdy = 1'b1;
        e = '{8'h00, 8'h0A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        addpg(1, DEF_VALUES);
        run({OP_SENSE10, 8'h08, VT_DEFAULT, PG_DEV_B, 32'h0, 16'h00FF,
             8'h00}, 12'h000);
        hd(8'h0F, 8'h08);
        run(s6(1'b0, VT_DEFAULT, PG_DEV_A, 8'h04), 12'h000);
        hd(8'h03, 8'h00);
        run(s6(1'b1, VT_CURRENT, PG_VENDOR0, 8'hFF), 12'h000);
        summarize();
    end
endmodule : mode_parameter_commands_test
